//--- hw/copro_regs.vh
// Constants for the coprocessor handshake sequencer
`ifndef COPRO_REGS_VH
`define COPRO_REGS_VH

// Sequencer states
`define STATE_IDLE        3'h0
`define STATE_FIRST       3'h1
`define STATE_BUSY        3'h2
`define STATE_XFER        3'h3
`define STATE_FETCH       3'h4

// Operation kinds on the request port
`define OP_DATA           1'h0
`define OP_LOAD           1'h1

// Address offsets from the instruction address, and the word step of a transfer
`define PC_PREFETCH_OFS   32'h00000008
`define PC_NEXT_OFS       32'h0000000C
`define WORD_STEP         32'h00000004

// Transfer width code for a word
`define WIDTH_WORD        2'h2

// Reset values of the bus indicators
`define RST_STROBE_N      1'h1
`define RST_REQ_N         1'h1
`define RST_BURST         1'h0
`define RST_OPC_N         1'h1
`define RST_WNR           1'h0

// Width of the words-moved counter
`define COUNT_W           8

`endif

//--- hw/copro_addr_step.v
// Incrementing transfer address and word counter for coprocessor loads
`timescale 1ns/1ps
`include "copro_regs.vh"

module copro_addr_step #(
  parameter ADDR_W  = 32,
  parameter COUNT_W = `COUNT_W
) (
  input  wire               core_clk,
  input  wire               reset_n,
  input  wire               load,
  input  wire [ADDR_W-1:0]  load_value,
  input  wire               step,
  output reg  [ADDR_W-1:0]  addr_reg,
  output wire [ADDR_W-1:0]  step_value,
  output reg  [COUNT_W-1:0] count_reg
);

  localparam [ADDR_W-1:0]  STEP = `WORD_STEP;
  localparam [COUNT_W-1:0] ONE  = {{(COUNT_W-1){1'b0}}, 1'b1};

  // Address of the word after the one now going out
  assign step_value = (load ? load_value : addr_reg) + STEP;

  ////////////////////////////////////////////////////////////////////////////
  // Load restarts the count; step advances both by one word
  always @(posedge core_clk) begin
    if (!reset_n) begin
      addr_reg  <= {ADDR_W{1'b0}};
      count_reg <= {COUNT_W{1'b0}};
    end else if (load) begin
      addr_reg  <= step_value;
      count_reg <= ONE;
    end else if (step) begin
      addr_reg  <= step_value;
      count_reg <= count_reg + ONE; // Wraps if the partner never ends
    end
  end

endmodule // copro_addr_step

//--- hw/coprocessor_handshake_sequencer.v
// Core-side sequencer for coprocessor data operations and loads
`timescale 1ns/1ps
`include "copro_regs.vh"

module coprocessor_handshake_sequencer #(
  parameter ADDR_W  = 32,
  parameter COUNT_W = `COUNT_W
) (
  input  wire               core_clk,
  input  wire               reset_n,
  input  wire               op_start,
  input  wire               op_kind,
  input  wire               compressed_state,
  input  wire [ADDR_W-1:0]  pc_in,
  input  wire [ADDR_W-1:0]  base_in,
  input  wire               copro_missing,
  input  wire               copro_wait,
  output reg  [ADDR_W-1:0]  mem_addr_reg,
  output reg                copro_instr_strobe_n_reg,
  output reg                mem_cycle_req_n_reg,
  output reg                burst_continue_reg,
  output reg                fetch_cycle_n_reg,
  output reg                write_not_read_reg,
  output reg  [1:0]         transfer_width_reg,
  output reg                busy_reg,
  output reg                done_reg,
  output reg                absent_trap_reg,
  output reg                refused_reg,
  output reg                base_wb_en_reg,
  output reg  [ADDR_W-1:0]  base_wb_value_reg,
  output reg  [COUNT_W-1:0] words_moved_reg
);

  localparam [2:0]        ST_IDLE  = `STATE_IDLE;
  localparam [2:0]        ST_FIRST = `STATE_FIRST;
  localparam [2:0]        ST_BUSY  = `STATE_BUSY;
  localparam [2:0]        ST_XFER  = `STATE_XFER;
  localparam [2:0]        ST_FETCH = `STATE_FETCH;
  localparam [ADDR_W-1:0] PF_OFS   = `PC_PREFETCH_OFS;
  localparam [ADDR_W-1:0] NX_OFS   = `PC_NEXT_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the partner's answer, used in several states

  // Both lines high: no coprocessor present, or the last transfer cycle
  function ans_end;
    input missing;
    input wait_l;
    begin
      ans_end = missing & wait_l;
    end
  endfunction

  // Missing low, wait high: able but not yet committed
  function ans_busy;
    input missing;
    input wait_l;
    begin
      ans_busy = ~missing & wait_l;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and held operands
  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg               kind_reg;
  reg               kind_next;
  reg  [ADDR_W-1:0] pc_reg;
  reg  [ADDR_W-1:0] pc_next;
  reg  [ADDR_W-1:0] xfer_base_reg;
  reg  [ADDR_W-1:0] xfer_base_next;

  // Next values of the bus outputs
  reg  [ADDR_W-1:0] mem_addr_next;
  reg               strobe_n_next;
  reg               req_n_next;
  reg               burst_next;
  reg               opc_n_next;
  reg               done_next;
  reg               absent_next;
  reg               refused_next;
  reg               wb_en_next;
  reg  [ADDR_W-1:0] wb_value_next;
  reg  [COUNT_W-1:0] words_next;

  // Address stepper controls
  reg               step_load;
  reg               step_adv;
  wire [ADDR_W-1:0] step_addr;
  wire [ADDR_W-1:0] step_value;
  wire [COUNT_W-1:0] step_count;

  // Partner lines count while our strobe is low, and in the transfer state with the strobe high
  wire              hs_active = ~copro_instr_strobe_n_reg;
  wire              is_end    = ans_end(copro_missing, copro_wait);
  wire              is_busy   = ans_busy(copro_missing, copro_wait);

  copro_addr_step #(
    .ADDR_W     (ADDR_W),
    .COUNT_W    (COUNT_W)
  ) u_addr_step (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .load       (step_load),
    .load_value (xfer_base_reg),
    .step       (step_adv),
    .addr_reg   (step_addr),
    .step_value (step_value),
    .count_reg  (step_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and next-output logic
  // The request and sequential indicators describe the access of the cycle
  // in which they are shown; they are set at the edge that ends the cycle
  // whose answer decides them, which keeps every output on a flip-flop.
  always @* begin
    state_next     = state_reg;
    kind_next      = kind_reg;
    pc_next        = pc_reg;
    xfer_base_next = xfer_base_reg;
    mem_addr_next  = mem_addr_reg;
    strobe_n_next  = 1'b1;
    req_n_next     = 1'b1;
    burst_next     = 1'b0;
    opc_n_next     = 1'b1;
    done_next      = 1'b0;
    absent_next    = 1'b0;
    refused_next   = 1'b0;
    wb_en_next     = 1'b0;
    wb_value_next  = base_wb_value_reg;
    words_next     = words_moved_reg;
    step_load      = 1'b0;
    step_adv       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (op_start && compressed_state) begin
          refused_next = 1'b1;
        end else if (op_start) begin
          // First cycle: strobe low, prefetch at pc+8 as an opcode fetch
          state_next     = ST_FIRST;
          kind_next      = op_kind;
          pc_next        = pc_in;
          xfer_base_next = base_in;
          mem_addr_next  = pc_in + PF_OFS;
          strobe_n_next  = 1'b0;
          req_n_next     = 1'b0;
          opc_n_next     = 1'b0;
        end
      end
      ST_FIRST, ST_BUSY: begin
        // Lines are read at every edge while the strobe is low
        if (hs_active && is_end) begin
          // Nobody answered: drop the strobe and report absence
          state_next  = ST_IDLE;
          absent_next = 1'b1;
        end else if (hs_active && is_busy) begin
          // Repeat the cycle, address stays at pc+8, no memory access
          state_next    = ST_BUSY;
          mem_addr_next = pc_reg + PF_OFS;
          strobe_n_next = 1'b0;
          req_n_next    = 1'b1;
        end else if (kind_reg == `OP_DATA) begin
          // Committed data operation: next is a non-sequential fetch
          state_next    = ST_FETCH;
          mem_addr_next = pc_reg + NX_OFS;
          req_n_next    = 1'b0;
          burst_next    = 1'b0;
        end else begin
          // Committed load: first word read, non-sequential
          state_next    = ST_XFER;
          mem_addr_next = xfer_base_reg;
          req_n_next    = 1'b0;
          burst_next    = 1'b0;
          step_load     = 1'b1;
          wb_en_next    = 1'b1;
          wb_value_next = step_value;
          words_next    = {{(COUNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_XFER: begin
        // Strobe is high here; the partner marks the last word itself
        if (is_end) begin
          state_next    = ST_FETCH;
          mem_addr_next = pc_reg + NX_OFS;
          req_n_next    = 1'b0;
          burst_next    = 1'b0;
        end else begin
          // One more word at the next address, sequential
          mem_addr_next = step_addr;
          req_n_next    = 1'b0;
          burst_next    = 1'b1;
          step_adv      = 1'b1;
          wb_en_next    = 1'b1;
          wb_value_next = step_value;
          words_next    = step_count + {{(COUNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_FETCH: begin
        // Next instruction fetch goes out; the handshake is over
        state_next = ST_IDLE;
        done_next  = 1'b1;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; every output is a flip-flop
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg                <= ST_IDLE;
      kind_reg                 <= `OP_DATA;
      pc_reg                   <= {ADDR_W{1'b0}};
      xfer_base_reg            <= {ADDR_W{1'b0}};
      mem_addr_reg             <= {ADDR_W{1'b0}};
      copro_instr_strobe_n_reg <= `RST_STROBE_N;
      mem_cycle_req_n_reg      <= `RST_REQ_N;
      burst_continue_reg       <= `RST_BURST;
      fetch_cycle_n_reg        <= `RST_OPC_N;
      write_not_read_reg       <= `RST_WNR;
      transfer_width_reg       <= `WIDTH_WORD;
      busy_reg                 <= 1'b0;
      done_reg                 <= 1'b0;
      absent_trap_reg          <= 1'b0;
      refused_reg              <= 1'b0;
      base_wb_en_reg           <= 1'b0;
      base_wb_value_reg        <= {ADDR_W{1'b0}};
      words_moved_reg          <= {COUNT_W{1'b0}};
    end else begin
      state_reg                <= state_next;
      kind_reg                 <= kind_next;
      pc_reg                   <= pc_next;
      xfer_base_reg            <= xfer_base_next;
      mem_addr_reg             <= mem_addr_next;
      copro_instr_strobe_n_reg <= strobe_n_next;
      mem_cycle_req_n_reg      <= req_n_next;
      burst_continue_reg       <= burst_next;
      fetch_cycle_n_reg        <= opc_n_next;
      // Only reads and word accesses occur in these sequences
      write_not_read_reg       <= 1'b0;
      transfer_width_reg       <= `WIDTH_WORD;
      busy_reg                 <= (state_next != ST_IDLE);
      done_reg                 <= done_next;
      absent_trap_reg          <= absent_next;
      refused_reg              <= refused_next;
      base_wb_en_reg           <= wb_en_next;
      base_wb_value_reg        <= wb_value_next;
      words_moved_reg          <= words_next;
    end
  end

endmodule // coprocessor_handshake_sequencer

//--- sim/copro_checker.sv
// Port assertions for the coprocessor handshake sequencer
`timescale 1ns/1ps
`include "copro_regs.vh"
module copro_checker #(
  parameter ADDR_W = 32
) (
  input logic              core_clk,
  input logic              reset_n,
  input logic              op_start,
  input logic              op_kind,
  input logic              compressed_state,
  input logic [ADDR_W-1:0] pc_in,
  input logic [ADDR_W-1:0] base_in,
  input logic              copro_missing,
  input logic              copro_wait,
  input logic [ADDR_W-1:0] mem_addr_reg,
  input logic              copro_instr_strobe_n_reg,
  input logic              mem_cycle_req_n_reg,
  input logic              burst_continue_reg,
  input logic              fetch_cycle_n_reg,
  input logic              write_not_read_reg,
  input logic [1:0]        transfer_width_reg,
  input logic              busy_reg,
  input logic              done_reg,
  input logic              absent_trap_reg,
  input logic              refused_reg,
  input logic              base_wb_en_reg,
  input logic [ADDR_W-1:0] base_wb_value_reg
);
  logic [ADDR_W-1:0] pc_hold_reg;
  logic [ADDR_W-1:0] base_hold_reg;
  logic              kind_hold_reg;
  logic              start_ok;
  logic              commit;
  assign start_ok = op_start && !busy_reg;
  assign commit   = !copro_instr_strobe_n_reg && !copro_wait;
  ////////////////////////////////////////////////////////////////////////////
  // Keep the accepted request; later cycles are judged against it
  always @(posedge core_clk) begin
    if (start_ok) begin
      pc_hold_reg   <= pc_in;
      base_hold_reg <= base_in;
      kind_hold_reg <= op_kind;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(reset_n) |-> copro_instr_strobe_n_reg && !busy_reg)
    else $error("strobe not idle after reset");
  first_cycle_a: assert property (start_ok && !compressed_state |=> !copro_instr_strobe_n_reg
    && !fetch_cycle_n_reg && mem_addr_reg == pc_hold_reg + `PC_PREFETCH_OFS)
    else $error("first cycle wrong");
  compressed_refuse_a: assert property (start_ok && compressed_state
    |=> refused_reg && copro_instr_strobe_n_reg)
    else $error("start not refused in compressed state");
  busy_hold_a: assert property (!copro_instr_strobe_n_reg && !copro_missing && copro_wait
    |=> !copro_instr_strobe_n_reg && mem_cycle_req_n_reg && fetch_cycle_n_reg && $stable(mem_addr_reg))
    else $error("busy cycle not held");
  absent_abort_a: assert property (!copro_instr_strobe_n_reg && copro_missing && copro_wait
    |=> absent_trap_reg && copro_instr_strobe_n_reg && !busy_reg)
    else $error("absent handshake not abandoned");
  data_ready_a: assert property (commit && !kind_hold_reg |=> copro_instr_strobe_n_reg
    && mem_addr_reg == pc_hold_reg + `PC_NEXT_OFS && !mem_cycle_req_n_reg && !burst_continue_reg ##1 done_reg)
    else $error("data operation end wrong");
  load_first_a: assert property (commit && kind_hold_reg |=> copro_instr_strobe_n_reg
    && mem_addr_reg == base_hold_reg && !burst_continue_reg && base_wb_en_reg
    && base_wb_value_reg == base_hold_reg + `WORD_STEP) else $error("first transfer wrong");
  load_step_a: assert property (base_wb_en_reg && !copro_missing && !copro_wait |=>
    mem_addr_reg == $past(mem_addr_reg) + `WORD_STEP && burst_continue_reg
    && transfer_width_reg == `WIDTH_WORD && !write_not_read_reg) else $error("transfer step wrong");
  load_last_a: assert property (base_wb_en_reg && copro_missing && copro_wait |=>
    mem_addr_reg == pc_hold_reg + `PC_NEXT_OFS && !burst_continue_reg && !mem_cycle_req_n_reg ##1 done_reg)
    else $error("transfer end wrong");
  cover property (done_reg);
  cover property (absent_trap_reg);
  cover property (base_wb_en_reg && !copro_wait ##1 base_wb_en_reg);
endmodule // copro_checker
bind coprocessor_handshake_sequencer copro_checker #(.ADDR_W(ADDR_W)) chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .op_start(op_start), .op_kind(op_kind),
  .compressed_state(compressed_state), .pc_in(pc_in), .base_in(base_in),
  .copro_missing(copro_missing),
  .copro_wait(copro_wait), .mem_addr_reg(mem_addr_reg),
  .copro_instr_strobe_n_reg(copro_instr_strobe_n_reg), .mem_cycle_req_n_reg(mem_cycle_req_n_reg),
  .burst_continue_reg(burst_continue_reg), .fetch_cycle_n_reg(fetch_cycle_n_reg),
  .write_not_read_reg(write_not_read_reg), .transfer_width_reg(transfer_width_reg),
  .busy_reg(busy_reg), .done_reg(done_reg), .absent_trap_reg(absent_trap_reg),
  .refused_reg(refused_reg), .base_wb_en_reg(base_wb_en_reg), .base_wb_value_reg(base_wb_value_reg));

//--- sim/copro_partner.sv
// Behavioural coprocessor answering the handshake lines
`timescale 1ns/1ps
module copro_partner (
  input  logic       core_clk,
  input  logic       reset_n,
  input  logic       strobe_n,
  input  logic       is_load,
  input  logic       absent_mode,
  input  logic [3:0] busy_n,
  input  logic [3:0] words_n,
  output logic       copro_missing,
  output logic       copro_wait
);
  logic [3:0] cnt_reg;
  logic [3:0] k_reg;
  logic       xfer_reg;
  logic       last;
  assign last = xfer_reg && (k_reg == words_n - 4'h1);
  ////////////////////////////////////////////////////////////////////////////
  // Idle lines float high, as a released pull-up would leave them
  always_comb begin
    if (!strobe_n) begin
      copro_missing = absent_mode;
      copro_wait    = absent_mode || (cnt_reg < busy_n);
    end else if (xfer_reg) begin
      copro_missing = last;
      copro_wait    = last;
    end else begin
      copro_missing = 1'h1;
      copro_wait    = 1'h1;
    end
  end
  // Busy count, then one word taken per transfer cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_reg  <= 4'h0;
      k_reg    <= 4'h0;
      xfer_reg <= 1'h0;
    end else begin
      cnt_reg <= strobe_n ? 4'h0 : cnt_reg + 4'h1;
      k_reg   <= xfer_reg ? k_reg + 4'h1 : 4'h0;
      if (!strobe_n && !copro_wait && is_load && !absent_mode) xfer_reg <= 1'h1;
      else if (last) xfer_reg <= 1'h0;
    end
  end
endmodule // copro_partner

//--- sim/tb_top.sv
// Self-checking bench for the coprocessor handshake sequencer
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic k; logic t; logic a; int b; int n; int res; int cyc;} row_t;
  // Kind, compressed, absent, busy, words | outcome, cycles to the end pulse
  row_t rows [7] = '{'{0,0,0,0,1,0,3}, '{0,0,0,2,1,0,5}, '{1,0,0,0,1,0,4}, '{1,0,0,0,3,0,6},
                     '{1,0,0,1,2,0,6}, '{0,0,1,0,1,1,2}, '{1,1,0,0,1,2,1}};
  logic        core_clk = 1'h0, reset_n = 1'h0, op_start = 1'h0, op_kind = 1'h0;
  logic        compressed_state = 1'h0, absent_mode = 1'h0;
  logic [3:0]  busy_n = 4'h0, words_n = 4'h1;
  logic [31:0] pc_in = 32'h00001000, base_in = 32'h00002000, mem_addr;
  logic        copro_missing, copro_wait, strobe_n, req_n, busy, done, absent, refused;
  logic [7:0]  words;
  int          n_errors = 0, checks = 0, cycles = 0, cyc, res;
  coprocessor_handshake_sequencer dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .op_start(op_start), .op_kind(op_kind), .compressed_state(compressed_state), .pc_in(pc_in),
    .base_in(base_in), .copro_missing(copro_missing), .copro_wait(copro_wait),
    .mem_addr_reg(mem_addr), .copro_instr_strobe_n_reg(strobe_n), .mem_cycle_req_n_reg(req_n),
    .burst_continue_reg(), .fetch_cycle_n_reg(), .write_not_read_reg(), .transfer_width_reg(),
    .busy_reg(busy), .done_reg(done), .absent_trap_reg(absent), .refused_reg(refused),
    .base_wb_en_reg(), .base_wb_value_reg(), .words_moved_reg(words));
  copro_partner partner_u (.core_clk(core_clk), .reset_n(reset_n), .strobe_n(strobe_n),
    .is_load(op_kind), .absent_mode(absent_mode), .busy_n(busy_n), .words_n(words_n),
    .copro_missing(copro_missing), .copro_wait(copro_wait));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock and a cycle ceiling well above the whole run
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Start one operation; with hold the start stays up into the busy cycle
  task automatic run(input row_t r, input bit hold, output int c, output int o);
    @(negedge core_clk);
    {op_kind, compressed_state, absent_mode} = {r.k, r.t, r.a};
    busy_n = r.b[3:0];
    words_n = r.n[3:0];
    op_start = 1'h1;
    c = 0;
    if (hold) begin
      @(negedge core_clk);
      c = 1;
    end
    @(negedge core_clk);
    op_start = 1'h0;
    c++;
    while (!(done | absent | refused) && c < 40) begin
      @(negedge core_clk);
      c++;
    end
    o = refused ? 2 : absent ? 1 : 0;
  endtask
  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      pc_in = pc_in + 32'h00000100;
      run(rows[i], 1'b0, cyc, res);
      chk("outcome", rows[i].res, res);
      chk("cycles", rows[i].cyc, cyc);
      if (rows[i].k && !rows[i].t) chk("words", rows[i].n, {24'h0, words});
    end
    // Second start while busy must be ignored
    run('{0,0,0,3,1,0,6}, 1'b1, cyc, res);
    chk("cycles_busy_start", 6, cyc);
    chk("outcome_busy_start", 0, res);
    @(negedge core_clk);
    chk("busy_after_done", 0, busy);
    // Four ready words, then reset in the middle of a second load
    run('{1,0,0,0,4,0,7}, 1'b0, cyc, res);
    chk("cycles_four_words", 7, cyc);
    chk("words_four", 4, {24'h0, words});
    @(negedge core_clk);
    @(negedge core_clk);
    op_start = 1'h1;
    @(negedge core_clk);
    op_start = 1'h0;
    @(negedge core_clk);
    reset_n = 1'h0;
    @(negedge core_clk);
    reset_n = 1'h1;
    chk("strobe_after_reset", 1, strobe_n);
    chk("req_after_reset", 1, req_n);
    chk("busy_after_reset", 0, busy);
    chk("addr_after_reset", 32'h0, mem_addr);
    // A data operation straight after the mid-run reset must run normally
    run(rows[0], 1'b0, cyc, res);
    chk("cycles_after_reset", 3, cyc);
    chk("outcome_after_reset", 0, res);
    finish_test();
  end
endmodule // tb_top
